// >>> core/instr_decode_pkg.sv
// Shared constants and types for the instruction format decoder
package instr_decode_pkg;
  localparam int INSTR_W       = 14;
  localparam int FILE_ADDR_W   = 7;
  localparam int BIT_SEL_W     = 3;
  localparam int LIT8_W        = 8;
  localparam int LIT11_W       = 11;
  localparam int PHASES        = 4;
  localparam logic [1:0] PHASE_LAST  = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  // Field positions
  localparam int DEST_BIT      = 7;
  localparam int BSEL_LSB      = 7;
  localparam int CLASS_MSB     = 13;
  // Opcode groups in the top two bits
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_CALL = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  // Byte-group sub opcodes, bits 11:8
  localparam logic [3:0] OP_MISC  = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  // Bit-group sub opcodes, bits 11:10
  localparam logic [1:0] OP_BTFSC = 2'h2;
  localparam logic [1:0] OP_BTFSS = 2'h3;
  // Reset values and the file address mask
  localparam logic [13:0] INSTR_RESET = 14'h0000;
  localparam logic [6:0]  ADDR_RESET  = 7'h00;
  localparam logic [10:0] LIT_RESET   = 11'h000;
  localparam logic [6:0]  FILE_ADDR_MAX = 7'h7F;

  typedef enum logic [1:0] {
    CLS_BYTE    = 2'h0,
    CLS_BIT     = 2'h1,
    CLS_LITERAL = 2'h3
  } instr_class_t;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_FLUSH = 2'h1
  } cycle_state_t;
endpackage

// >>> core/instruction_format_decode.sv
`timescale 1ns/1ps
// Instruction format decoder with single/two-cycle execution control
// How it works
// - Sort instructions into byte, bit, literal classes
// - Split 14-bit word into opcode and operands
// - Destination bit zero writes accumulator, else file
// - File address spans 0x00 to 0x7F
// - Bit select picks one bit of register
// - Literal is 8 or 11 bits wide
// - Don't-care bits never change the decode
// - One instruction cycle is four clock periods
// - Most instructions finish in one cycle
// - Taken skip or branch adds NOP cycle
// - File instructions always read before writing
// - Clearing first port reads it first
module instruction_format_decode
  import instr_decode_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [INSTR_W-1:0]   prog_word,
  input  wire logic                 skip_true,
  output logic [INSTR_W-1:0]        instr_q,
  output logic [1:0]                instr_class_q,
  output logic [FILE_ADDR_W-1:0]    file_addr_q,
  output logic                      dest_file_q,
  output logic                      dest_accum_q,
  output logic [7:0]                bit_mask_q,
  output logic [LIT11_W-1:0]        literal_q,
  output logic                      lit_wide_q,
  output logic                      file_read_q,
  output logic                      file_write_q,
  output logic                      nop_cycle_q,
  output logic                      fetch_q,
  output logic [1:0]                phase_q
);
  logic [1:0]   phase;
  logic         cycle_end;
  cycle_state_t state_q;
  logic         flow_change;
  logic         cond_skip;

  quarter_phase_gen u_phase (
    .clk       (clk),
    .reset     (reset),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // Classify by the top two bits; calls and gotos fall into the literal class
  function automatic logic [1:0] classify(input logic [INSTR_W-1:0] w);
    unique case (w[CLASS_MSB -: 2])
      GRP_BYTE: classify = CLS_BYTE;
      GRP_BIT:  classify = CLS_BIT;
      default:  classify = CLS_LITERAL;
    endcase
  endfunction

  // True for instructions that touch a file register
  function automatic logic names_file(input logic [INSTR_W-1:0] w);
    logic byte_file;
    byte_file = (w[11:8] != OP_MISC) || w[DEST_BIT];
    names_file = (w[13:12] == GRP_BIT) || ((w[13:12] == GRP_BYTE) && byte_file);
  endfunction

  // Branch, call, return and pc-writing byte ops change the pc
  always_comb begin
    flow_change = (instr_q[13:12] == GRP_CALL)
               || (instr_q[13:7] == 7'h00 && instr_q[3:1] == 3'h4)      // return family
               || (instr_q[13:10] == 4'hD)                              // literal return
               || (instr_q[13:12] == GRP_BYTE && instr_q[DEST_BIT]
                   && instr_q[6:0] == 7'h02);
    cond_skip = ((instr_q[13:12] == GRP_BYTE)
                 && (instr_q[11:8] == OP_DECSZ || instr_q[11:8] == OP_INCSZ))
             || ((instr_q[13:12] == GRP_BIT)
                 && (instr_q[11:10] == OP_BTFSC || instr_q[11:10] == OP_BTFSS));
  end

  // Execution state: a taken test or pc change flushes one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_EXEC;
    end else if (cycle_end) begin
      if (state_q == ST_EXEC && (flow_change || (cond_skip && skip_true))) begin
        state_q <= ST_FLUSH;
      end else begin
        state_q <= ST_EXEC;
      end
    end
  end

  // Latch the fetched word at the instruction-cycle boundary
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_q <= INSTR_RESET;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= cycle_end;
      if (cycle_end) begin
        instr_q <= prog_word;
      end
    end
  end

  // Operand field extraction; unused bits never reach a decision
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_class_q <= CLS_BYTE;
      file_addr_q   <= ADDR_RESET;
      dest_file_q   <= 1'b0;
      dest_accum_q  <= 1'b0;
      bit_mask_q    <= 8'h00;
      literal_q     <= LIT_RESET;
      lit_wide_q    <= 1'b0;
    end else begin
      instr_class_q <= classify(instr_q);
      file_addr_q   <= instr_q[FILE_ADDR_W-1:0] & FILE_ADDR_MAX;
      dest_file_q   <= (instr_q[13:12] == GRP_BYTE) && instr_q[DEST_BIT];
      dest_accum_q  <= (instr_q[13:12] == GRP_BYTE) && !instr_q[DEST_BIT];
      bit_mask_q    <= (instr_q[13:12] == GRP_BIT)
                     ? (8'h01 << instr_q[BSEL_LSB +: BIT_SEL_W]) : 8'h00;
      lit_wide_q    <= (instr_q[13:12] == GRP_CALL);
      literal_q     <= (instr_q[13:12] == GRP_CALL) ? instr_q[LIT11_W-1:0]
                     : {3'h0, instr_q[LIT8_W-1:0]};
    end
  end

  // Read in Q2 for every file-register instruction outside a flushed cycle; write in Q4 only for bit ops and file-destination byte ops
  always_ff @(posedge clk) begin
    if (reset) begin
      file_read_q  <= 1'b0;
      file_write_q <= 1'b0;
    end else begin
      // Clear-file still reads, so first_io_port mismatch is cleared
      file_read_q  <= (state_q == ST_EXEC) && names_file(instr_q) && (phase == 2'h0);
      file_write_q <= (state_q == ST_EXEC) && names_file(instr_q)
                      && (instr_q[13:12] == GRP_BIT || instr_q[DEST_BIT])
                      && (phase == 2'h2);
    end
  end

  // Flag the no-operation cycle and publish the phase
  always_ff @(posedge clk) begin
    if (reset) begin
      nop_cycle_q <= 1'b0;
      phase_q     <= PHASE_RESET;
    end else begin
      nop_cycle_q <= (state_q == ST_FLUSH);
      phase_q     <= phase;
    end
  end

  // Read always precedes write by two clocks
  rmw_order_a: assert property (@(posedge clk) disable iff (reset)
    file_write_q |-> $past(file_read_q, 2))
    else $error("file write without prior read");

  // Cycle end pulses every four clocks
  cycle_period_a: assert property (@(posedge clk) disable iff (reset)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle not four clocks");

  // No file write during the flushed cycle
  nop_quiet_a: assert property (@(posedge clk) disable iff (reset)
    nop_cycle_q |-> !file_write_q)
    else $error("write during nop cycle");

  // Accumulator and file destination exclusive
  dest_excl_a: assert property (@(posedge clk) disable iff (reset)
    !(dest_file_q && dest_accum_q))
    else $error("two destinations selected");

  // Bit mask is one-hot or empty
  bit_onehot_a: assert property (@(posedge clk) disable iff (reset)
    $onehot0(bit_mask_q))
    else $error("bit mask not one-hot");

  // Flush lasts only one instruction cycle
  flush_once_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_FLUSH && cycle_end) |=> state_q == ST_EXEC)
    else $error("flush longer than one cycle");

  // Goto leads to a flushed cycle
  goto_flush_a: assert property (@(posedge clk) disable iff (reset)
    (cycle_end && state_q == ST_EXEC && instr_q[13:12] == GRP_CALL)
    |=> state_q == ST_FLUSH)
    else $error("branch not flushed");

  // Narrow literal has zero upper bits
  lit_width_a: assert property (@(posedge clk) disable iff (reset)
    !lit_wide_q |-> literal_q[10:8] == 3'h0)
    else $error("narrow literal too wide");

  // Every executed file instruction reads in its second clock
  file_read_a: assert property (@(posedge clk) disable iff (reset)
    (fetch_q && state_q == ST_EXEC && names_file(instr_q)) |=> file_read_q)
    else $error("file instruction without read");

  // Clearing a file register still reads it first
  clear_reads_a: assert property (@(posedge clk) disable iff (reset)
    (fetch_q && state_q == ST_EXEC && instr_q[13:8] == {GRP_BYTE, OP_CLR}
     && instr_q[DEST_BIT]) |=> file_read_q)
    else $error("clear without read");

  // Writes land only in the fourth clock after capture
  write_slot_a: assert property (@(posedge clk) disable iff (reset)
    file_write_q |-> $past(fetch_q, 3))
    else $error("file write off its slot");

  // Taken test flushes the following cycle
  skip_flush_a: assert property (@(posedge clk) disable iff (reset)
    (cycle_end && state_q == ST_EXEC && cond_skip && skip_true) |=> state_q == ST_FLUSH)
    else $error("taken skip not flushed");

  // Untaken test or plain operation stays single cycle
  single_cycle_a: assert property (@(posedge clk) disable iff (reset)
    (cycle_end && state_q == ST_EXEC && !flow_change && !(cond_skip && skip_true))
    |=> state_q == ST_EXEC)
    else $error("plain instruction flushed");

  // Writing the program counter register flushes
  pc_write_flush_a: assert property (@(posedge clk) disable iff (reset)
    (cycle_end && state_q == ST_EXEC && instr_q[13:12] == GRP_BYTE && instr_q[DEST_BIT]
     && instr_q[6:0] == 7'h02) |=> state_q == ST_FLUSH)
    else $error("pc write not flushed");

  // Flushed cycle never reads a file register
  nop_noread_a: assert property (@(posedge clk) disable iff (reset)
    nop_cycle_q |-> !file_read_q)
    else $error("read during nop cycle");
endmodule

// >>> core/quarter_phase_gen.sv
`timescale 1ns/1ps
// Four-phase instruction-cycle generator
module quarter_phase_gen
  import instr_decode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  output logic [1:0]      phase,
  output logic            cycle_end
);
  // Phase counter walks Q1..Q4 once per instruction cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // One-cycle pulse on the last of four periods
  always_ff @(posedge clk) begin
    if (reset) begin
      cycle_end <= 1'b0;
    end else begin
      cycle_end <= (phase == PHASE_LAST - 2'h1);
    end
  end
endmodule

// >>> test/prog_mem_model.sv
`timescale 1ns/1ps
// Program memory model that hands the decoder one word per instruction cycle
module prog_mem_model
  import instr_decode_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               fetch,
  output logic [INSTR_W-1:0]      word
);
  logic [INSTR_W-1:0] rom [0:15];
  logic [3:0]         ptr_q;

  // Test program: one word per scenario step, spare slots load a literal
  initial begin
    for (int i = 0; i < 16; i++) rom[i] = 14'h3000;
    rom[1]  = 14'h07FF;
    rom[2]  = 14'h0700;
    rom[3]  = 14'h0185;
    rom[4]  = 14'h17A0;
    rom[5]  = 14'h1803;
    rom[6]  = 14'h0790;
    rom[7]  = 14'h30A5;
    rom[8]  = 14'h33A5;
    rom[9]  = 14'h2DA3;
    rom[10] = 14'h30FF;
    rom[11] = 14'h077F;
    rom[13] = 14'h0082;
  end

  // Move to the next word only after the decoder has taken the current one
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_q <= 4'h0;
    end else if (fetch) begin
      ptr_q <= ptr_q + 4'h1;
    end
  end

  // Word changes one clock after capture and then holds, so the next capture edge always sees it
  assign word = rom[ptr_q];
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
// Self-checking testbench for the instruction format decoder
module testbench;
  import instr_decode_pkg::*;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 skip_true = 1'b0;
  logic [INSTR_W-1:0]   prog_word, instr_q;
  logic [LIT11_W-1:0]   literal_q;
  logic [1:0]           instr_class_q, phase_q;
  logic [6:0]           file_addr_q;
  logic [7:0]           bit_mask_q;
  logic                 dest_file_q, dest_accum_q, lit_wide_q;
  logic                 file_read_q, file_write_q, nop_cycle_q, fetch_q;
  int                   error_cnt = 0;
  int                   n_tests = 0;
  int                   rd_n, wr_n, nop_n;

  // Clock at 50 ns period
  always #25 clk = ~clk;

  instruction_format_decode dut_u (.clk(clk), .reset(reset), .prog_word(prog_word),
    .skip_true(skip_true), .instr_q(instr_q), .instr_class_q(instr_class_q),
    .file_addr_q(file_addr_q), .dest_file_q(dest_file_q), .dest_accum_q(dest_accum_q),
    .bit_mask_q(bit_mask_q), .literal_q(literal_q), .lit_wide_q(lit_wide_q),
    .file_read_q(file_read_q), .file_write_q(file_write_q), .nop_cycle_q(nop_cycle_q),
    .fetch_q(fetch_q), .phase_q(phase_q));

  prog_mem_model mem_u (.clk(clk), .reset(reset), .fetch(fetch_q), .word(prog_word));

  // Compare one value and count it
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Run one instruction cycle, counting strobes over its four clocks
  task automatic step(input logic skip);
    @(negedge clk);
    chk("fetch", 14'h0001, 14'(fetch_q));
    skip_true = skip;
    rd_n = 0;
    wr_n = 0;
    nop_n = 0;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) @(negedge clk);
      chk("phase", 14'((i + 3) % 4), 14'(phase_q));
      if (i > 0) chk("fetch", 14'h0000, 14'(fetch_q));
      if (file_read_q === 1'b1) rd_n++;
      if (file_write_q === 1'b1) wr_n++;
      if (i > 0 && nop_cycle_q === 1'b1) nop_n++;
    end
  endtask

  task automatic t_byte();
    step(1'b0);
    chk("instr", 14'h07FF, instr_q);
    chk("class", 14'h0000, 14'(instr_class_q));
    chk("addr", 14'h007F, 14'(file_addr_q));
    chk("to_file", 14'h0001, 14'(dest_file_q));
    chk("rw", 14'h0101, 14'({rd_n[5:0], wr_n[7:0]}));
    step(1'b0);
    chk("addr", 14'h0000, 14'(file_addr_q));
    chk("to_acc", 14'h0001, 14'(dest_accum_q));
    chk("rw", 14'h0100, 14'({rd_n[5:0], wr_n[7:0]}));
    $display("test byte done");
  endtask

  task automatic t_clear_port();
    step(1'b0);
    chk("addr", 14'h0005, 14'(file_addr_q));
    chk("rw", 14'h0101, 14'({rd_n[5:0], wr_n[7:0]}));
    $display("test clear port done");
  endtask

  task automatic t_bit_skip();
    step(1'b0);
    chk("class", 14'h0001, 14'(instr_class_q));
    chk("mask", 14'h0080, 14'(bit_mask_q));
    chk("rw", 14'h0101, 14'({rd_n[5:0], wr_n[7:0]}));
    step(1'b1);
    chk("mask", 14'h0001, 14'(bit_mask_q));
    chk("rw", 14'h0101, 14'({rd_n[5:0], wr_n[7:0]}));
    step(1'b0);
    chk("nop", 14'h0001, 14'(nop_n > 0));
    chk("rw", 14'h0000, 14'({rd_n[5:0], wr_n[7:0]}));
    $display("test bit skip done");
  endtask

  // Byte op storing to the program counter register costs a flushed cycle
  task automatic t_pc_write();
    step(1'b0);
    chk("to_file", 14'h0001, 14'(dest_file_q));
    chk("rw", 14'h0101, 14'({rd_n[5:0], wr_n[7:0]}));
    step(1'b0);
    chk("nop", 14'h0001, 14'(nop_n > 0));
    chk("rw", 14'h0000, 14'({rd_n[5:0], wr_n[7:0]}));
    $display("test pc write done");
  endtask

  task automatic t_literal();
    step(1'b0);
    chk("class", 14'h0003, 14'(instr_class_q));
    chk("lit8", 14'h00A5, 14'({lit_wide_q, literal_q}));
    step(1'b0);
    chk("lit8x", 14'h00A5, 14'({lit_wide_q, literal_q}));
    chk("rd", 14'h0000, 14'(rd_n));
    step(1'b0);
    chk("lit11", 14'h0DA3, 14'({lit_wide_q, literal_q}));
    step(1'b0);
    chk("nop", 14'h0001, 14'(nop_n > 0));
    $display("test literal done");
  endtask

  task automatic t_single();
    step(1'b1);
    chk("rd", 14'h0001, 14'(rd_n));
    step(1'b0);
    chk("nop", 14'h0000, 14'(nop_n));
    $display("test single done");
  endtask

  // Print the verdict and stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 85 clocks
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 20 && fetch_q !== 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    t_byte();
    t_clear_port();
    t_bit_skip();
    t_literal();
    t_single();
    t_pc_write();
    complete_run();
  end
endmodule
